// ### dv/card_side_model.sv
// Far-side model: card sockets watching selects and enables
`timescale 1ns/10ps
module card_side_model (
  input wire logic clk,
  input wire logic area5_select_n,
  input wire logic area6_select_n,
  input wire logic card_a_second_enable_n,
  input wire logic card_b_second_enable_n,
  output logic bad_enable
);
  initial bad_enable = 1'b0;
  always @(negedge clk) begin
    if ((card_a_second_enable_n === 1'b0 && area5_select_n !== 1'b0) ||
        (card_b_second_enable_n === 1'b0 && area6_select_n !== 1'b0)) begin
      bad_enable <= 1'b1;
    end
  end
endmodule

// ### dv/physical_area_decoder_test.sv
// Self-checking bench for the physical area decoder
`timescale 1ns/10ps
module physical_area_decoder_test;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  area_decode_pkg::access_t req = '0;
  area_decode_pkg::bus_ctl_t bctl;
  logic p5 = 1'b0;
  logic p6 = 1'b0;
  logic shi = 1'b1;
  logic slo = 1'b1;
  logic s0, s2, s3, s4, s5, s6, ce_a, ce_b, rsv, rdy, bad_en;
  area_decode_pkg::width_t bw;
  logic [5:0] selv;
  logic [1:0] ce_seen;
  int error_cnt = 0;
  int total_checks = 0;

  always #50 clk = ~clk;
  assign selv = {s6, s5, s4, s3, s2, s0};

  physical_area_decoder DUT (.clk(clk), .resetn(resetn), .req(req),
    .bus_control_two(bctl), .area5_pcmcia(p5), .area6_pcmcia(p6),
    .width_strap_hi(shi), .width_strap_lo(slo), .area0_select_n(s0),
    .area2_select_n(s2), .area3_select_n(s3), .area4_select_n(s4),
    .area5_select_n(s5), .area6_select_n(s6),
    .card_a_second_enable_n(ce_a), .card_b_second_enable_n(ce_b),
    .bus_width(bw), .reserved_access(rsv), .strap_ready(rdy));

  card_side_model far_side (.clk(clk), .area5_select_n(s5),
    .area6_select_n(s6), .card_a_second_enable_n(ce_a),
    .card_b_second_enable_n(ce_b), .bad_enable(bad_en));

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Straps are only sampled after a reset
  task automatic do_reset(input logic [1:0] s);
    int n;
    @(negedge clk);
    resetn = 1'b0;
    {shi, slo} = s;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    n = 0;
    while (rdy !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk(rdy === 1'b1, "strap not captured");
  endtask

  // One request cycle, then one idle cycle
  task automatic access(input logic [31:0] a, input logic [3:0] be,
                        output logic [5:0] sv, output logic r);
    @(negedge clk);
    req = '{1'b1, a, be};
    @(negedge clk);
    sv = selv;
    r = rsv;
    ce_seen = {ce_b, ce_a};
    req.valid = 1'b0;
    @(negedge clk);
    chk(selv === 6'h3f && rsv === 1'b0 && ce_a === 1'b1 &&
        ce_b === 1'b1, "select held after request");
  endtask

  function automatic logic [5:0] exp_sel(input int c);
    exp_sel = 6'h3f;
    if (c == 0) exp_sel[0] = 1'b0;
    if (c >= 2 && c <= 6) exp_sel[c-1] = 1'b0;
  endfunction

  task automatic strap_widths();
    logic [5:0] sv;
    logic r;
    for (int s = 1; s <= 3; s++) begin
      do_reset(s[1:0]);
      access(32'h03ffffff + 32'h20000000 * s, 4'hf, sv, r);
      chk(sv === 6'h3e, "area 0 top not selected");
      chk(bw === area_decode_pkg::width_t'(s), "strap width");
    end
  endtask

  task automatic area_walk();
    logic [5:0] sv;
    logic r;
    logic [31:0] a;
    area_decode_pkg::width_t ew[7];
    ew = '{area_decode_pkg::WIDTH_32, area_decode_pkg::WIDTH_RSVD,
      bctl.area2, bctl.area3, bctl.area4, bctl.area5, bctl.area6};
    for (int n = 0; n < 8; n++) begin
      for (int c = 0; c < 8; c++) begin
        a = (32'h20000000 * n) | (32'h04000000 * c) | 32'h00000124;
        access(a, 4'h1, sv, r);
        chk(sv === exp_sel(c), "wrong area select");
        chk(r === (c == 7), "reserved flag");
        if (c != 1 && c != 7) chk(bw === ew[c], "area width");
      end
    end
  endtask

  task automatic card_enables();
    logic [5:0] sv;
    logic r;
    p5 = 1'b1;
    p6 = 1'b1;
    access(32'h14000002, 4'h4, sv, r);
    chk(sv === 6'h2f && ce_seen[0] === 1'b1, "even lane enable");
    access(32'h14000002, 4'h8, sv, r);
    chk(sv === 6'h2f && ce_seen[0] === 1'b0, "upper lane enable");
    chk(ce_a === 1'b1, "enable in idle cycle");
    @(negedge clk);
    req = '{1'b1, 32'h34000000, 4'h2};
    @(negedge clk);
    chk(s5 === 1'b0 && ce_a === 1'b0, "odd lane enable");
    req = '{1'b1, 32'h18000000, 4'h8};
    @(negedge clk);
    // card on area 6 narrowed to 8 bits
    chk(s6 === 1'b0 && ce_b === 1'b1, "8-bit card enable");
    req.valid = 1'b0;
    bctl.area6 = area_decode_pkg::WIDTH_16;
    access(32'h18000000, 4'h8, sv, r);
    chk(sv === 6'h1f && ce_seen[1] === 1'b0, "area 6 card enable");
    chk(bad_en === 1'b0, "enable without select");
    p5 = 1'b0;
    access(32'h14000000, 4'h2, sv, r);
    chk(sv === 6'h2f && ce_seen[0] === 1'b1, "non-card enable");
  endtask

  // Back-to-back requests across the area 0 top edge
  task automatic map_boundary();
    @(negedge clk);
    req = '{1'b1, 32'h03ffffff, 4'hf};
    @(negedge clk);
    chk(s0 === 1'b0 && s4 === 1'b1, "area 0 top");
    req = '{1'b1, 32'h10000000, 4'hf};
    @(negedge clk);
    chk(s4 === 1'b0 && s0 === 1'b1, "area 4 base");
    req.valid = 1'b0;
    @(negedge clk);
    chk(selv === 6'h3f, "select after boundary pair");
  endtask

  initial begin
    bctl = '{area_decode_pkg::WIDTH_8, area_decode_pkg::WIDTH_16,
      area_decode_pkg::WIDTH_32, area_decode_pkg::WIDTH_16,
      area_decode_pkg::WIDTH_16};
    strap_widths();
    area_walk();
    map_boundary();
    card_enables();
    report_and_stop();
  end

  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
endmodule

// ### hdl/area_decode_pkg.sv
// Shared types and constants for the physical area decoder
package area_decode_pkg;

  localparam int ADDR_W = 32;
  localparam int AREA_MSB = 28;
  localparam int AREA_LSB = 26;
  localparam int SHADOW_MSB = 31;
  localparam int SHADOW_LSB = 29;
  localparam int BE_W = 4;
  localparam int SEL_W = 8;
  localparam int BE_ODD_LO = 1;
  localparam int BE_ODD_HI = 3;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef enum logic [2:0] {
    AREA0 = 3'h0,
    AREA1 = 3'h1,
    AREA2 = 3'h2,
    AREA3 = 3'h3,
    AREA4 = 3'h4,
    AREA5 = 3'h5,
    AREA6 = 3'h6,
    AREA7 = 3'h7
  } area_t;

  // Same coding as the two width straps, upper bit first
  typedef enum logic [1:0] {
    WIDTH_RSVD = 2'h0,
    WIDTH_8 = 2'h1,
    WIDTH_16 = 2'h2,
    WIDTH_32 = 2'h3
  } width_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [BE_W-1:0] byte_en;
  } access_t;

  // Per-area width fields of the second bus-control register
  typedef struct packed {
    width_t area6;
    width_t area5;
    width_t area4;
    width_t area3;
    width_t area2;
  } bus_ctl_t;

endpackage

// ### hdl/area_width_sel.sv
// Picks the external bus width for the area being accessed
`timescale 1ns/10ps
module area_width_sel (
  input wire area_decode_pkg::area_t area,
  input wire area_decode_pkg::width_t strap_width,
  input wire area_decode_pkg::bus_ctl_t bus_control_two,
  output area_decode_pkg::width_t width
);

  always_comb begin
    unique case (area)
      area_decode_pkg::AREA0: width = strap_width;
      area_decode_pkg::AREA2: width = bus_control_two.area2;
      area_decode_pkg::AREA3: width = bus_control_two.area3;
      area_decode_pkg::AREA4: width = bus_control_two.area4;
      area_decode_pkg::AREA5: width = bus_control_two.area5;
      area_decode_pkg::AREA6: width = bus_control_two.area6;
      // Internal registers and reserved space have no external width
      area_decode_pkg::AREA1: width = area_decode_pkg::WIDTH_RSVD;
      area_decode_pkg::AREA7: width = area_decode_pkg::WIDTH_RSVD;
    endcase
  end

endmodule

// ### hdl/physical_area_decoder.sv
// Physical area decoder: area selects, card enables, bus width
`timescale 1ns/10ps
module physical_area_decoder (
  input wire logic clk,
  input wire logic resetn,
  input wire area_decode_pkg::access_t req,
  input wire area_decode_pkg::bus_ctl_t bus_control_two,
  input wire logic area5_pcmcia,
  input wire logic area6_pcmcia,
  input wire logic width_strap_hi,
  input wire logic width_strap_lo,
  output logic area0_select_n,
  output logic area2_select_n,
  output logic area3_select_n,
  output logic area4_select_n,
  output logic area5_select_n,
  output logic area6_select_n,
  output logic card_a_second_enable_n,
  output logic card_b_second_enable_n,
  output area_decode_pkg::width_t bus_width,
  output logic reserved_access,
  output logic strap_ready
);

  function automatic area_decode_pkg::area_t area_of(
    input logic [area_decode_pkg::ADDR_W-1:0] addr
  );
    area_of = area_decode_pkg::area_t'(
      addr[area_decode_pkg::AREA_MSB:area_decode_pkg::AREA_LSB]);
  endfunction

  // Strap synchroniser and capture
  logic [2:0] hi_sync_q, hi_sync_d;
  logic [2:0] lo_sync_q, lo_sync_d;
  logic [1:0] settle_q, settle_d;
  logic strap_ready_q, strap_ready_d;
  area_decode_pkg::width_t strap_width_q, strap_width_d;

  always_comb begin
    hi_sync_d = {hi_sync_q[1:0], width_strap_hi};
    lo_sync_d = {lo_sync_q[1:0], width_strap_lo};
    settle_d = settle_q;
    strap_ready_d = strap_ready_q;
    strap_width_d = strap_width_q;
    if (settle_q != area_decode_pkg::STRAP_SETTLE) begin
      settle_d = settle_q + 2'h1;
    end else if (!strap_ready_q && hi_sync_q[1] == hi_sync_q[2] &&
                 lo_sync_q[1] == lo_sync_q[2]) begin
      strap_ready_d = 1'b1;
      strap_width_d = area_decode_pkg::width_t'(
        {hi_sync_q[2], lo_sync_q[2]});
    end
  end

  // Sampled only after release, so the flops reset to constants
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_sync_q <= 3'h0;
      lo_sync_q <= 3'h0;
      settle_q <= 2'h0;
      strap_ready_q <= 1'b0;
      strap_width_q <= area_decode_pkg::WIDTH_RSVD;
    end else begin
      hi_sync_q <= hi_sync_d;
      lo_sync_q <= lo_sync_d;
      settle_q <= settle_d;
      strap_ready_q <= strap_ready_d;
      strap_width_q <= strap_width_d;
    end
  end

  // Access decode
  area_decode_pkg::area_t area;
  area_decode_pkg::width_t width;
  logic hit, pcmcia, odd_bytes, ce2;
  // Held active low so each pin comes straight off a flop
  logic [area_decode_pkg::SEL_W-1:0] sel_n_q, sel_n_d;
  logic card_a_second_enable_n_n_q, card_a_second_enable_n_n_d, card_b_second_enable_n_n_q, card_b_second_enable_n_n_d;
  logic rsvd_q, rsvd_d;
  area_decode_pkg::width_t width_q, width_d;

  area_width_sel u_width (
    .area(area),
    .strap_width(strap_width_q),
    .bus_control_two(bus_control_two),
    .width(width)
  );

  always_comb begin
    area = area_of(req.addr);
    // area 1 and reserved area drive nothing
    hit = req.valid && strap_ready_q &&
          area != area_decode_pkg::AREA1 &&
          area != area_decode_pkg::AREA7;
    for (int i = 0; i < area_decode_pkg::SEL_W; i++) begin
      sel_n_d[i] = !(hit && (area == area_decode_pkg::area_t'(i)));
    end
    // card mode only in 5 and 6
    pcmcia = (area == area_decode_pkg::AREA5 && area5_pcmcia) ||
             (area == area_decode_pkg::AREA6 && area6_pcmcia);
    odd_bytes = req.byte_en[area_decode_pkg::BE_ODD_LO] ||
                req.byte_en[area_decode_pkg::BE_ODD_HI];
    // upper byte lane of a 16-bit card
    ce2 = hit && pcmcia && width == area_decode_pkg::WIDTH_16 &&
          odd_bytes;
    card_a_second_enable_n_n_d = !(ce2 && area == area_decode_pkg::AREA5);
    card_b_second_enable_n_n_d = !(ce2 && area == area_decode_pkg::AREA6);
    // flag a forbidden access, nothing else
    rsvd_d = req.valid && area == area_decode_pkg::AREA7;
    width_d = hit ? width : width_q;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_n_q <= '1;
      card_a_second_enable_n_n_q <= 1'b1;
      card_b_second_enable_n_n_q <= 1'b1;
      rsvd_q <= 1'b0;
      width_q <= area_decode_pkg::WIDTH_RSVD;
    end else begin
      sel_n_q <= sel_n_d;
      card_a_second_enable_n_n_q <= card_a_second_enable_n_n_d;
      card_b_second_enable_n_n_q <= card_b_second_enable_n_n_d;
      rsvd_q <= rsvd_d;
      width_q <= width_d;
    end
  end

  assign area0_select_n = sel_n_q[area_decode_pkg::AREA0];
  assign area2_select_n = sel_n_q[area_decode_pkg::AREA2];
  assign area3_select_n = sel_n_q[area_decode_pkg::AREA3];
  assign area4_select_n = sel_n_q[area_decode_pkg::AREA4];
  assign area5_select_n = sel_n_q[area_decode_pkg::AREA5];
  assign area6_select_n = sel_n_q[area_decode_pkg::AREA6];
  assign card_a_second_enable_n = card_a_second_enable_n_n_q;
  assign card_b_second_enable_n = card_b_second_enable_n_n_q;
  assign bus_width = width_q;
  assign reserved_access = rsvd_q;
  assign strap_ready = strap_ready_q;

  // Checks
  logic go;
  logic [2:0] code;
  logic [1:0] cfg2;
  logic [5:0] sels_n;
  assign go = req.valid && strap_ready_q;
  assign code = req.addr[area_decode_pkg::AREA_MSB:area_decode_pkg::AREA_LSB];
  assign cfg2 = bus_control_two.area2;
  assign sels_n = {area0_select_n, area2_select_n, area3_select_n,
                   area4_select_n, area5_select_n, area6_select_n};

  sequence s_area0_req;
    go && code == 3'h0;
  endsequence

  sequence s_area2_req;
    go && code == 3'h2;
  endsequence

  property p_code_sel;
    @(posedge clk) disable iff (!resetn)
      go && code == 3'h6 |=> !area6_select_n && area5_select_n;
  endproperty
  a_code_sel: assert property (p_code_sel)
    else $error("area 6 code did not select area 6");

  property p_shadow;
    @(posedge clk) disable iff (!resetn)
      go && req.addr[31:29] != 3'h0 && code == 3'h3 |=> !area3_select_n;
  endproperty
  a_shadow: assert property (p_shadow)
    else $error("shadow address did not select its area");

  property p_one_sel;
    @(posedge clk) disable iff (!resetn)
      !req.valid |=> sels_n == 6'h3f ##1 $countones(~sels_n) <= 1;
  endproperty
  a_one_sel: assert property (p_one_sel)
    else $error("select active without access or more than one");

  property p_card;
    @(posedge clk) disable iff (!resetn)
      go && code == 3'h5 && area5_pcmcia &&
      bus_control_two.area5 == area_decode_pkg::WIDTH_16 &&
      req.byte_en[1] |=> !area5_select_n && !card_a_second_enable_n;
  endproperty
  a_card: assert property (p_card)
    else $error("card enable pair missing for area 5");

  property p_strap;
    @(posedge clk) disable iff (!resetn)
      $rose(strap_ready_q) |-> strap_width_q ==
        area_decode_pkg::width_t'({$past(hi_sync_q[2]), $past(lo_sync_q[2])});
  endproperty
  a_strap: assert property (p_strap)
    else $error("area 0 width differs from straps");

  property p_area0_width;
    @(posedge clk) disable iff (!resetn)
      s_area0_req |=> bus_width == strap_width_q && !area0_select_n;
  endproperty
  a_area0_width: assert property (p_area0_width)
    else $error("area 0 width not from straps");

  property p_reg_width;
    @(posedge clk) disable iff (!resetn)
      s_area2_req |=> bus_width == $past(cfg2);
  endproperty
  a_reg_width: assert property (p_reg_width)
    else $error("area 2 width not from register");

  property p_map;
    @(posedge clk) disable iff (!resetn)
      go && req.addr == 32'h03ffffff ##1 go && req.addr == 32'h10000000
      |-> !area0_select_n ##1 !area4_select_n;
  endproperty
  a_map: assert property (p_map)
    else $error("64 Mbyte map boundary wrong");

  property p_area1;
    @(posedge clk) disable iff (!resetn)
      req.valid && code == 3'h1 |=> sels_n == 6'h3f;
  endproperty
  a_area1: assert property (p_area1)
    else $error("external select on area 1 access");

  property p_card_areas;
    @(posedge clk) disable iff (!resetn)
      code != 3'h5 && code != 3'h6 |=>
        card_a_second_enable_n && card_b_second_enable_n;
  endproperty
  a_card_areas: assert property (p_card_areas)
    else $error("card enable outside areas 5 and 6");

endmodule
